// file: ssb_rx_top.sv
// buffered synchronous serial receive unit: registers, buffer control, serial sampling
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
module ssb_rx_top #(
  parameter logic [7:0] HALF_SEL0 = ssb_pkg::HALF_SEL0,
  parameter logic [7:0] HALF_SEL1 = ssb_pkg::HALF_SEL1,
  parameter logic [7:0] HALF_SEL2 = ssb_pkg::HALF_SEL2
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [ssb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  input wire logic serial_data_in,
  output logic transfer_busy,
  output logic irq_out
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic go;
    logic gap_interval_select;
    logic overrun_flag;
    logic wt;
    logic [7:0] start_ptr;
    logic [7:0] end_ptr;
    logic irq_flag;
    logic irq_en;
    logic [4:0] ptr;
    logic [7:0] shift;
    logic [2:0] bitcnt;
    logic ck_s1;
    logic ck_s2;
    logic ck_prev;
    logic dat_s1;
    logic dat_s2;
    logic [1:0] low_cnt;
    logic [7:0] rd_data;
    logic irq_out;
    logic oe_n;
  } ssb_rx_state_t;

  ssb_rx_state_t st_reg;
  ssb_rx_state_t st_next;

  // combinational helpers, not state
  logic ext_clk;
  logic ext_rise;
  logic gen_rise;
  logic gen_level;
  logic sample;
  logic is_buf;
  logic violation;
  logic overrun;
  logic [7:0] half_period;
  logic buf_we;
  logic [4:0] buf_waddr;
  logic [7:0] buf_wdata;
  logic [7:0] buf_rdata;
  logic [7:0] rx_byte;
  logic [7:0] stat_view;

  ssb_buf #(
    .DEPTH(ssb_pkg::BUF_DEPTH),
    .AW(ssb_pkg::PTR_W),
    .DW(ssb_pkg::DATA_W)
  ) u_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_en(buf_we),
    .wr_addr(buf_waddr),
    .wr_data(buf_wdata),
    .rd_addr(reg_addr[4:0]),
    .rd_data(buf_rdata)
  );

  // gap applies only to transmit direction on an internal clock
  ssb_sclk_gen u_sclk (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(st_reg.go && !ext_clk), // internal source runs straight from go [RULE5]
    .half_period(half_period),
    .gap_en(st_reg.ctrl[ssb_pkg::CTRL_DIR_BIT] && !ext_clk), // [RULE10]
    .gap_len({st_reg.ctrl[ssb_pkg::CTRL_GAP_HI_BIT], st_reg.ctrl[ssb_pkg::CTRL_GAP_LO_BIT]}),
    .gap_every16(st_reg.gap_interval_select), // [RULE11]
    .sclk_level(gen_level),
    .sclk_rise(gen_rise)
  );

  // clock source and rate decode
  always_comb begin
    ext_clk = (st_reg.ctrl[ssb_pkg::CTRL_CKSEL_HI:ssb_pkg::CTRL_CKSEL_LO] == ssb_pkg::CKSEL_EXT);
    case (st_reg.ctrl[ssb_pkg::CTRL_CKSEL_HI:ssb_pkg::CTRL_CKSEL_LO])
      2'h0: half_period = HALF_SEL0;
      2'h1: half_period = HALF_SEL1;
      2'h2: half_period = HALF_SEL2;
      default: half_period = HALF_SEL0;
    endcase
  end

  // status view; go reads as busy flag
  always_comb begin
    stat_view = 8'h00;
    stat_view[ssb_pkg::STAT_GO_BIT] = st_reg.go;
    stat_view[ssb_pkg::STAT_GIT_BIT] = st_reg.gap_interval_select;
    stat_view[ssb_pkg::STAT_OVR_BIT] = st_reg.overrun_flag; // cause stays visible [RULE14]
    stat_view[ssb_pkg::STAT_WT_BIT] = st_reg.wt; // [RULE14]
  end

  // main next-state process: bus access first, hardware events last so a set wins
  always_comb begin
    st_next = st_reg;
    st_next.rd_data = 8'h00;
    violation = 1'b0;
    overrun = 1'b0;
    buf_we = 1'b0;
    buf_waddr = reg_addr[4:0];
    buf_wdata = reg_wdata;
    rx_byte = 8'h00;
    is_buf = !reg_addr[ssb_pkg::BUF_SEL_BIT];

    // two-stage synchronisers for clock pin and data pin
    st_next.ck_s1 = serial_clock_pin_in;
    st_next.ck_s2 = st_reg.ck_s1;
    st_next.ck_prev = st_reg.ck_s2;
    st_next.dat_s1 = serial_data_in;
    st_next.dat_s2 = st_reg.dat_s1;
    ext_rise = st_reg.ck_s2 && !st_reg.ck_prev;

    // length of the current low phase of the external clock, saturating
    if (st_reg.ck_s2) begin
      st_next.low_cnt = 2'h0;
    end else if (st_reg.low_cnt != 2'h3) begin
      st_next.low_cnt = 2'(st_reg.low_cnt + 2'h1);
    end

    // register and buffer writes
    if (reg_wr) begin
      if (is_buf) begin
        if (st_reg.go) begin
          violation = 1'b1; // write dropped while busy [RULE19] [RULE8]
        end else begin
          buf_we = 1'b1;
        end
      end else begin
        case (reg_addr)
          ssb_pkg::CTRL_OFS: begin
            st_next.ctrl = reg_wdata;
          end
          ssb_pkg::STAT_OFS: begin
            st_next.go = reg_wdata[ssb_pkg::STAT_GO_BIT];
            st_next.gap_interval_select = reg_wdata[ssb_pkg::STAT_GIT_BIT];
            // error flags clear by writing zero, ones are ignored
            st_next.overrun_flag = st_reg.overrun_flag & reg_wdata[ssb_pkg::STAT_OVR_BIT];
            st_next.wt = st_reg.wt & reg_wdata[ssb_pkg::STAT_WT_BIT];
            if (reg_wdata[ssb_pkg::STAT_GO_BIT] && !st_reg.go) begin
              st_next.ptr = st_reg.start_ptr[4:0]; // first entry from start [RULE2]
              st_next.bitcnt = 3'h0;
              st_next.shift = 8'h00;
            end
            if (!reg_wdata[ssb_pkg::STAT_GO_BIT]) begin
              // abort: sequencer back to rest, buffer and registers kept [RULE18]
              st_next.bitcnt = 3'h0;
              st_next.shift = 8'h00;
            end
          end
          ssb_pkg::START_OFS: begin
            st_next.start_ptr = reg_wdata;
          end
          ssb_pkg::END_OFS: begin
            st_next.end_ptr = reg_wdata;
          end
          ssb_pkg::IRQ_REQ_OFS: begin
            st_next.irq_flag = st_reg.irq_flag & reg_wdata[ssb_pkg::IRQ_BIT];
          end
          ssb_pkg::IRQ_EN_OFS: begin
            st_next.irq_en = reg_wdata[ssb_pkg::IRQ_BIT];
          end
          default: begin
          end
        endcase
      end
    end

    // reads, data stands one cycle after the strobe only
    if (reg_rd) begin
      if (is_buf) begin
        if (st_reg.go) begin
          st_next.rd_data = ssb_pkg::BUSY_READ; // all ones while busy [RULE19]
          violation = 1'b1; // [RULE8]
        end else begin
          st_next.rd_data = buf_rdata;
        end
      end else begin
        case (reg_addr)
          ssb_pkg::CTRL_OFS: st_next.rd_data = st_reg.ctrl;
          ssb_pkg::STAT_OFS: st_next.rd_data = stat_view;
          ssb_pkg::START_OFS: st_next.rd_data = st_reg.start_ptr;
          ssb_pkg::END_OFS: st_next.rd_data = st_reg.end_ptr;
          ssb_pkg::IRQ_REQ_OFS: st_next.rd_data = {7'h00, st_reg.irq_flag};
          ssb_pkg::IRQ_EN_OFS: st_next.rd_data = {7'h00, st_reg.irq_en};
          default: st_next.rd_data = 8'h00;
        endcase
      end
    end

    // one bit per rising serial edge, only while go is set [RULE6] [RULE7]
    sample = st_reg.go && (ext_clk ? ext_rise : gen_rise); // [RULE20]

    // a low phase shorter than the sampling window means bits were missed
    if (st_reg.go && ext_clk && ext_rise && (st_reg.low_cnt < ssb_pkg::OVR_MIN_LOW)) begin
      overrun = 1'b1;
    end

    if (sample) begin
      // lsb arrives first, so shift right and enter at the top [RULE20]
      rx_byte = {st_reg.dat_s2, st_reg.shift[7:1]};
      st_next.shift = rx_byte;
      st_next.bitcnt = 3'(st_reg.bitcnt + 3'h1);
      if (st_reg.bitcnt == ssb_pkg::LAST_BIT) begin
        // byte complete: store at pointer, serial write beats the bus [RULE22]
        if (!st_reg.ctrl[ssb_pkg::CTRL_DIR_BIT]) begin
          buf_we = 1'b1;
          buf_waddr = st_reg.ptr;
          buf_wdata = rx_byte;
        end
        if (st_reg.ptr == st_reg.end_ptr[4:0]) begin
          st_next.go = 1'b0; // [RULE3] [RULE4]
          st_next.irq_flag = 1'b1; // [RULE4] [RULE12]
        end else begin
          st_next.ptr = 5'(st_reg.ptr + 5'h01); // 31 rolls to 0 [RULE21] [RULE22]
        end
      end
    end

    // error events set last so they win over a same-cycle clear
    if (violation) begin
      st_next.wt = 1'b1; // [RULE8]
      st_next.irq_flag = 1'b1; // shared request [RULE12]
    end
    if (overrun) begin
      st_next.overrun_flag = 1'b1; // [RULE9]
    end

    // request gated by its enable [RULE13]
    st_next.irq_out = st_next.irq_flag && st_next.irq_en;
    // pin driven only for an internal source while busy [RULE5]
    st_next.oe_n = !(st_next.go &&
      (st_next.ctrl[ssb_pkg::CTRL_CKSEL_HI:ssb_pkg::CTRL_CKSEL_LO] != ssb_pkg::CKSEL_EXT));
  end

  // asynchronous reset loads constants only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      // clock pin synchronisers start at the idle-high clock level, so no false edge follows reset
      st_reg <= '{ctrl: ssb_pkg::CTRL_RST, start_ptr: ssb_pkg::START_RST,
                  end_ptr: ssb_pkg::END_RST, ck_s1: 1'b1, ck_s2: 1'b1, ck_prev: 1'b1,
                  oe_n: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = st_reg.rd_data;
  assign serial_clock_pin_out = gen_level;
  assign serial_clock_pin_oe_n = st_reg.oe_n;
  assign transfer_busy = st_reg.go;
  assign irq_out = st_reg.irq_out;
endmodule

// file: ssb_pkg.sv
// constants, field layouts and types shared by the buffered serial receive block
//
// Contract
// RULE1: software selects receive direction and clock source before starting
// RULE2: first byte lands at buffer entry given by start pointer low five bits
// RULE3: reception ends once the entry named by end pointer is filled
// RULE4: on completion the request flag is set and the go flag cleared
// RULE5: internal clock starts at once on go and drives the clock pin
// RULE6: external clock samples data with edges seen on the clock pin after go
// RULE7: after completion further external edges are ignored until go again
// RULE8: buffer access during transfer sets request flag and access violation flag
// RULE9: an overrun condition sets the overrun flag
// RULE10: gaps only in transmit with internal clock, clock held high meanwhile
// RULE11: two gap bits give gap length, status bit picks 8 or 16 bit spacing
// RULE12: completion and buffer access share one request flag
// RULE13: request reaches the processor only while its enable bit is set
// RULE14: overrun and violation flags stay readable to tell the cause apart
// RULE15: software should not write registers while go reads one
// RULE16: software selects serial input pin function and no chip select for receive
// RULE17: software reads received bytes only after go returns to zero
// RULE18: clearing go mid transfer stops and reinitialises, buffer and registers kept
// RULE19: during transfer buffer writes are dropped and reads return all ones
// RULE20: data moves lsb first, bits latched on serial clock rising edge
// RULE21: start above end wraps from last entry to first, on to end
// RULE22: every eight bits form a byte stored at the pointer, then it advances
package ssb_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 32;
  localparam int PTR_W = 5;
  // register map, buffer occupies offsets 0x00 to 0x1F
  localparam logic [5:0] CTRL_OFS = 6'h20;
  localparam logic [5:0] STAT_OFS = 6'h21;
  localparam logic [5:0] START_OFS = 6'h22;
  localparam logic [5:0] END_OFS = 6'h23;
  localparam logic [5:0] IRQ_REQ_OFS = 6'h24;
  localparam logic [5:0] IRQ_EN_OFS = 6'h25;
  localparam int BUF_SEL_BIT = 5;
  // serial_control_reg fields
  localparam int CTRL_DIR_BIT = 7;
  localparam int CTRL_GAP_HI_BIT = 4;
  localparam int CTRL_GAP_LO_BIT = 3;
  localparam int CTRL_CKSEL_HI = 1;
  localparam int CTRL_CKSEL_LO = 0;
  localparam logic [1:0] CKSEL_EXT = 2'h3;
  // serial_status_reg fields
  localparam int STAT_GO_BIT = 7;
  localparam int STAT_GIT_BIT = 6;
  localparam int STAT_OVR_BIT = 1;
  localparam int STAT_WT_BIT = 0;
  localparam int IRQ_BIT = 0;
  // reset values and the all-ones buffer read value while busy
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] START_RST = 8'h00;
  localparam logic [7:0] END_RST = 8'h00;
  localparam logic [7:0] BUSY_READ = 8'hFF;
  // internal clock half periods in ref_clk cycles, one per source select
  localparam logic [7:0] HALF_SEL0 = 8'h02;
  localparam logic [7:0] HALF_SEL1 = 8'h08;
  localparam logic [7:0] HALF_SEL2 = 8'h20;
  // shortest low phase of the external clock that still counts as sound
  localparam logic [1:0] OVR_MIN_LOW = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] LAST_BIT16 = 4'hF;
  typedef enum logic {CK_IDLE, CK_RUN} ssb_ck_state_t;
endpackage

// file: ssb_buf.sv
// 32-entry byte buffer with one write port and one combinational read port
`timescale 1ns/100ps
module ssb_buf #(
  parameter int DEPTH = ssb_pkg::BUF_DEPTH,
  parameter int AW = ssb_pkg::PTR_W,
  parameter int DW = ssb_pkg::DATA_W
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
  } ssb_buf_state_t;

  ssb_buf_state_t st_reg;
  ssb_buf_state_t st_next;

  // single write per cycle, the caller arbitrates between bus and serial side
  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.mem[rd_addr];
endmodule

// file: ssb_sclk_gen.sv
// internal serial clock generator with gap insertion at data divisions
`timescale 1ns/100ps
module ssb_sclk_gen (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [7:0] half_period,
  input wire logic gap_en,
  input wire logic [1:0] gap_len,
  input wire logic gap_every16,
  output logic sclk_level,
  output logic sclk_rise
);
  typedef struct packed {
    ssb_pkg::ssb_ck_state_t state;
    logic level;
    logic rise;
    logic [7:0] timer;
    logic [3:0] bitcnt;
    logic [2:0] gapc;
  } ssb_ck_t;

  ssb_ck_t st_reg;
  ssb_ck_t st_next;
  logic boundary;

  // clock idles high, falls first, every rise is one bit time
  always_comb begin
    st_next = st_reg;
    st_next.rise = 1'b0;
    boundary = 1'b0;
    case (st_reg.state)
      ssb_pkg::CK_IDLE: begin
        st_next.level = 1'b1;
        st_next.timer = 8'h00;
        st_next.bitcnt = 4'h0;
        st_next.gapc = 3'h0;
        if (run) begin
          st_next.state = ssb_pkg::CK_RUN; // starts with no wait [RULE5]
        end
      end
      ssb_pkg::CK_RUN: begin
        if (!run) begin
          st_next.state = ssb_pkg::CK_IDLE;
          st_next.level = 1'b1;
        end else if (8'(st_reg.timer + 8'h01) >= half_period) begin
          st_next.timer = 8'h00;
          if (st_reg.level) begin
            // held high while gap half periods remain [RULE10]
            if (st_reg.gapc != 3'h0) begin
              st_next.gapc = 3'(st_reg.gapc - 3'h1);
            end else begin
              st_next.level = 1'b0;
            end
          end else begin
            st_next.level = 1'b1;
            st_next.rise = 1'b1;
            st_next.bitcnt = 4'(st_reg.bitcnt + 4'h1);
            // spacing of 8 or 16 bits, length in whole clock cycles [RULE11]
            boundary = gap_every16 ? (st_reg.bitcnt == ssb_pkg::LAST_BIT16)
                                   : (st_reg.bitcnt[2:0] == ssb_pkg::LAST_BIT);
            if (gap_en && boundary) begin
              st_next.gapc = {gap_len, 1'b0};
            end
          end
        end else begin
          st_next.timer = 8'(st_reg.timer + 8'h01);
        end
      end
      default: begin
        st_next.state = ssb_pkg::CK_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{state: ssb_pkg::CK_IDLE, level: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sclk_level = st_reg.level;
  assign sclk_rise = st_reg.rise;
endmodule

// file: ssb_rx_props.sv
// port-level assertions for the buffered serial receive unit
`timescale 1ns/100ps
module ssb_rx_props (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [ssb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_clock_pin_in,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe_n,
  input wire logic serial_data_in,
  input wire logic transfer_busy,
  input wire logic irq_out
);
  logic en_reg;
  logic ext_reg;
  logic stat_wr;
  logic buf_hit;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // shadow of enable bit and clock source, since neither shows at the ports
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_reg <= 1'b0;
      ext_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == ssb_pkg::IRQ_EN_OFS) en_reg <= reg_wdata[0];
      if (reg_addr == ssb_pkg::CTRL_OFS) ext_reg <= (reg_wdata[1:0] == ssb_pkg::CKSEL_EXT);
    end
  end
  // decoded bus events
  assign stat_wr = reg_wr && reg_addr == ssb_pkg::STAT_OFS;
  assign buf_hit = (reg_wr || reg_rd) && !reg_addr[ssb_pkg::BUF_SEL_BIT];
  sequence go_write(bit v);
    stat_wr && reg_wdata[7] == v;
  endsequence
  // busy dropped by itself, not by a software abort
  sequence finished;
    $fell(transfer_busy) ##0 !$past(stat_wr);
  endsequence
  sequence busy_access;
    buf_hit && transfer_busy;
  endsequence
  a_go_start: assert property (go_write(1'b1) |=> transfer_busy)
    else $error("go write did not start a transfer");
  a_go_abort: assert property (go_write(1'b0) |=> !transfer_busy)
    else $error("go clear did not stop the transfer");
  a_done_irq: assert property (finished ##0 en_reg |=> irq_out)
    else $error("no interrupt after completion");
  a_irq_masked: assert property (!en_reg && !$past(en_reg) |-> !irq_out)
    else $error("interrupt seen while disabled");
  a_busy_read: assert property (reg_rd and busy_access |=> reg_rdata == ssb_pkg::BUSY_READ)
    else $error("busy buffer read not all ones");
  a_viol_irq: assert property (busy_access ##0 en_reg |-> ##2 irq_out)
    else $error("busy buffer access raised no interrupt");
  a_oe_int: assert property (transfer_busy && $past(transfer_busy) && !ext_reg
    |-> !serial_clock_pin_oe_n)
    else $error("internal clock not driven while busy");
  a_oe_ext: assert property (ext_reg && $past(ext_reg) |-> serial_clock_pin_oe_n)
    else $error("clock pin driven with external source");
  a_clk_idle: assert property (!transfer_busy [*3] |-> serial_clock_pin_out)
    else $error("serial clock not idle high");
endmodule

// file: ssb_peer.sv
// far-side serial peer: link clock, data pin and bit queue
`timescale 1ns/100ps
module ssb_peer (
  input wire logic dut_clk,
  output logic ext_clk,
  output logic sdata
);
  bit bq[$];
  // link clock stands high between frames
  initial begin
    ext_clk = 1'b1;
    sdata = 1'b0;
  end
  // next queued bit, or the inverse of the last once the queue is spent
  function automatic logic nxt(input logic last);
    return bq.size() > 0 ? bq.pop_front() : ~last;
  endfunction
  // queue a byte least significant bit first
  task automatic load(input logic [7:0] b);
    for (int i = 0; i < 8; i++) bq.push_back(b[i]);
  endtask
  // period stays 160 ns so the phase to the system clock never drifts
  task automatic frame(input int n, input int lo);
    #3;
    repeat (n) begin
      ext_clk = 1'b0;
      sdata = nxt(sdata);
      #(lo);
      ext_clk = 1'b1;
      #(160 - lo);
    end
    sdata = ~sdata;
  endtask
  // internal source: new bit on every fall of the unit's clock
  always @(negedge dut_clk) sdata = nxt(sdata);
endmodule

// file: tb.sv
// self-checking bench for the buffered serial receive unit
`timescale 1ns/100ps
module tb;
  logic ref_clk;
  logic arst_n;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic sck_out;
  logic sck_oe_n;
  logic ext_clk;
  logic sdata;
  logic transfer_busy;
  logic irq_out;
  logic [7:0] lf;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int mbuf[32];
  int hi_max = 0;
  wire sck_pin = sck_oe_n ? ext_clk : sck_out;
  ssb_rx_top #(.HALF_SEL0(8'h04)) DUT (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .serial_clock_pin_in(sck_pin), .serial_clock_pin_out(sck_out),
    .serial_clock_pin_oe_n(sck_oe_n), .serial_data_in(sdata), .transfer_busy, .irq_out);
  ssb_peer peer (.dut_clk(sck_out), .ext_clk(ext_clk), .sdata(sdata));
  function automatic logic [7:0] nx(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bus cycles start right after a clock edge and leave one idle cycle
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    cmp(nm, e, d);
    @(posedge ref_clk);
  endtask
  // registers stay untouched until go reads zero again
  // also tracks the longest high stretch of the driven clock while busy
  task automatic wait_idle;
    int n;
    int run;
    n = 0;
    run = 0;
    hi_max = 0;
    @(posedge ref_clk);
    while (transfer_busy !== 1'b0 && n < 3000) begin
      run = (sck_out === 1'b1) ? run + 1 : 0;
      if (run > hi_max) hi_max = run;
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) err_total++;
  endtask
  // program a run, feed random bytes to peer and model, then set go
  task automatic start_rx(input logic [7:0] ctl, input int s, input int e, input int nb);
    int p;
    wr(ssb_pkg::CTRL_OFS, ctl);
    wr(ssb_pkg::START_OFS, {3'h6, s[4:0]});
    wr(ssb_pkg::END_OFS, {3'h5, e[4:0]});
    p = s;
    repeat (nb) begin
      lf = nx(lf);
      mbuf[p] = lf;
      peer.load(lf);
      p = (p + 1) % 32;
    end
    wr(ssb_pkg::STAT_OFS, 8'h80);
  endtask
  task automatic chkbuf(input int s, input int nb);
    int p;
    p = s;
    repeat (nb) begin
      rc(p[5:0], mbuf[p][7:0], "buffer");
      p = (p + 1) % 32;
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard, far above the under two thousand cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    arst_n = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lf = 8'h4B;
    foreach (mbuf[i]) mbuf[i] = 0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    for (int a = 32; a < 40; a++) rc(a[5:0], 8'h00, "reset value");
    wr(ssb_pkg::IRQ_EN_OFS, 8'h01);
    start_rx(8'h03, 30, 1, 4);
    fork
      peer.frame(32, 80);
      begin
        rc(6'h1E, 8'hFF, "busy read");
        wr(6'h02, 8'h55);
      end
    join
    wait_idle;
    cmp("irq_out", 8'h01, {7'h0, irq_out});
    rc(ssb_pkg::STAT_OFS, 8'h01, "status");
    chkbuf(30, 4);
    peer.frame(8, 80);
    repeat (8) @(posedge ref_clk);
    cmp("busy", 8'h00, {7'h0, transfer_busy});
    rc(6'h02, 8'h00, "past end");
    wr(ssb_pkg::STAT_OFS, 8'h00);
    wr(ssb_pkg::IRQ_REQ_OFS, 8'h00);
    wr(ssb_pkg::IRQ_EN_OFS, 8'h00);
    start_rx(8'h18, 5, 6, 2);
    wait_idle;
    cmp("rx clock high", 8'h04, hi_max[7:0]);
    cmp("irq_out", 8'h00, {7'h0, irq_out});
    rc(ssb_pkg::IRQ_REQ_OFS, 8'h01, "irq request");
    wr(ssb_pkg::IRQ_EN_OFS, 8'h01);
    cmp("irq_out", 8'h01, {7'h0, irq_out});
    chkbuf(5, 2);
    // transmit on source 1: half period 8, one-cycle gap adds two half periods high
    start_rx(8'h89, 20, 21, 2);
    wait_idle;
    cmp("gap clock high", 8'h18, hi_max[7:0]);
    rc(6'h14, 8'h00, "tx no store");
    wr(ssb_pkg::IRQ_REQ_OFS, 8'h00);
    start_rx(8'h03, 10, 10, 1);
    peer.frame(8, 8);
    wait_idle;
    rc(ssb_pkg::STAT_OFS, 8'h02, "overrun");
    wr(ssb_pkg::STAT_OFS, 8'h00);
    wr(ssb_pkg::IRQ_REQ_OFS, 8'h00);
    start_rx(8'h03, 12, 20, 2);
    peer.frame(8, 80);
    repeat (8) @(posedge ref_clk);
    wr(ssb_pkg::STAT_OFS, 8'h00);
    cmp("busy", 8'h00, {7'h0, transfer_busy});
    peer.frame(8, 80);
    repeat (8) @(posedge ref_clk);
    chkbuf(12, 1);
    rc(6'h0D, 8'h00, "after abort");
    rc(ssb_pkg::START_OFS, 8'hCC, "start pointer");
    rc(ssb_pkg::IRQ_REQ_OFS, 8'h00, "irq request");
    wrap_up;
  end
endmodule
bind ssb_rx_top ssb_rx_props chk (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe_n,
  .serial_data_in, .transfer_busy, .irq_out);
